/* File: fbam_top.sv */
`timescale 1ns/1ns
`default_nettype none
module fbam_top
   import fbam_pkg::*;
(
   input  wire logic              I_CLK,
   input  wire logic              I_RSTN,
   input  wire logic              I_REQ,
   input  wire logic [31:0]       I_ADDR,
   input  wire fbam_cfg_type      I_CODE_CFG,
   input  wire fbam_cfg_type      I_WORK_CFG,
   output fbam_sel_type           O_SEL,
   output logic                   O_VALID,
   output logic                   O_ERR
);


   // Number of arrays behind the mapper and the slot of each in every table
   localparam int unsigned ARR_NUM  = 2;
   localparam int unsigned IDX_CODE = 0;
   localparam int unsigned IDX_WORK = 1;

   // Geometry of each array, indexed by slot
   localparam logic [31:0] BASE0_TAB      [ARR_NUM] = '{CF_BASE0,      WF_BASE0};
   localparam logic [31:0] BASE1_TAB      [ARR_NUM] = '{CF_BASE1,      WF_BASE1};
   localparam logic [31:0] LARGE_SIZE_TAB [ARR_NUM] = '{CF_LARGE_SIZE, WF_LARGE_SIZE};
   localparam logic [31:0] SMALL_SIZE_TAB [ARR_NUM] = '{CF_SMALL_SIZE, WF_SMALL_SIZE};
   localparam logic [7:0]  LARGE_NUM_TAB  [ARR_NUM] = '{CF_LARGE_NUM,  WF_LARGE_NUM};
   localparam logic [7:0]  SMALL_NUM_TAB  [ARR_NUM] = '{CF_SMALL_NUM,  WF_SMALL_NUM};

   // Bank setting of each array; each array has its own dual_bank and map_b bits
   fbam_cfg_type        cfg_arr  [ARR_NUM];

   // Raw decoder answers, one bit or field per array
   wire  [ARR_NUM-1:0]  hit_vec;
   wire  [ARR_NUM-1:0]  half_vec;
   wire  [ARR_NUM-1:0]  large_vec;
   wire  [SECT_W-1:0]   sect_arr [ARR_NUM];
   wire  [OFF_W-1:0]    off_arr  [ARR_NUM];

   // Priority pick and the selects that the arrays contribute
   wire  [ARR_NUM-1:0]  win_vec;
   fbam_sel_type        part_arr [ARR_NUM];
   fbam_sel_type        or_arr   [ARR_NUM+1];

   // Request outcome
   wire                 hit_any;
   wire                 req_hit;
   wire                 req_miss;

   // Next and registered value of every answer field
   fbam_arr_type        arr_d;
   fbam_arr_type        arr_q;
   logic                half_d;
   logic                half_q;
   logic                large_d;
   logic                large_q;
   logic [SECT_W-1:0]   sect_d;
   logic [SECT_W-1:0]   sect_q;
   logic [OFF_W-1:0]    off_d;
   logic [OFF_W-1:0]    off_q;
   logic                valid_d;
   logic                valid_q;
   logic                err_d;
   logic                err_q;

   // True when slot idx hits and no slot of lower index does.
   // The windows never overlap; the pick keeps the select one-hot
   // even if a table entry were ever set to overlap another.
   function automatic logic is_winner(input logic [ARR_NUM-1:0] hits,
                                      input int unsigned       idx);
      logic lower;
      lower = 1'h0;
      for (int unsigned k = 0; k < ARR_NUM; k++) begin
         if (k < idx) begin
            lower = lower | hits[k];
         end
      end
      is_winner = hits[idx] & ~lower;
   endfunction

   // Array code reported for a slot
   function automatic fbam_arr_type arr_code(input int unsigned idx);
      case (idx)
         IDX_CODE: arr_code = FBAM_ARR_CODE;
         IDX_WORK: arr_code = FBAM_ARR_WORK;
         default:  arr_code = FBAM_ARR_NONE;
      endcase
   endfunction

   // Route each array's own bank setting to its slot
   assign cfg_arr[IDX_CODE] = I_CODE_CFG;
   assign cfg_arr[IDX_WORK] = I_WORK_CFG;

   // The merge chain starts from an empty select
   assign or_arr[0] = '0;

   // One decoder per array finds sector, offset and physical half;
   // the winning array alone feeds the merged select
   genvar g;
   generate
      for (g = 0; g < ARR_NUM; g = g + 1) begin : g_arr
         fbam_decode #(
            .BASE0      (BASE0_TAB[g]),
            .BASE1      (BASE1_TAB[g]),
            .LARGE_SIZE (LARGE_SIZE_TAB[g]),
            .SMALL_SIZE (SMALL_SIZE_TAB[g]),
            .LARGE_NUM  (LARGE_NUM_TAB[g]),
            .SMALL_NUM  (SMALL_NUM_TAB[g])
         ) fbam_decode_inst (
            .i_addr         (I_ADDR),
            .i_cfg          (cfg_arr[g]),
            .o_hit          (hit_vec[g]),
            .o_half         (half_vec[g]),
            .o_large_sector (large_vec[g]),
            .o_sector       (sect_arr[g]),
            .o_offset       (off_arr[g])
         );

         // Losing arrays contribute all zeros
         assign win_vec[g]                = is_winner(hit_vec, g);
         assign part_arr[g].arr           = win_vec[g] ? arr_code(g) : FBAM_ARR_NONE;
         assign part_arr[g].half          = win_vec[g] & half_vec[g];
         assign part_arr[g].large_sector  = win_vec[g] & large_vec[g];
         assign part_arr[g].sector        = win_vec[g] ? sect_arr[g] : '0;
         assign part_arr[g].offset        = win_vec[g] ? off_arr[g] : '0;

         // Merge by OR; at most one contribution is non-zero
         assign or_arr[g+1] = or_arr[g] | part_arr[g];
      end
   endgenerate

   // A request that hits no sector is a decode error and selects nothing
   assign hit_any  = |hit_vec;
   assign req_hit  = I_REQ & hit_any;
   assign req_miss = I_REQ & ~hit_any;

   // Next values: every select field is zero unless the request hit
   assign arr_d   = req_hit ? or_arr[ARR_NUM].arr : FBAM_ARR_NONE;
   assign half_d  = req_hit & or_arr[ARR_NUM].half;
   assign large_d = req_hit & or_arr[ARR_NUM].large_sector;
   assign sect_d  = req_hit ? or_arr[ARR_NUM].sector : '0;
   assign off_d   = req_hit ? or_arr[ARR_NUM].offset : '0;
   assign valid_d = req_hit;
   assign err_d   = req_miss;

   // Array field of the answer
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         arr_q <= FBAM_ARR_NONE;
      end else begin
         arr_q <= arr_d;
      end
   end

   // Physical half field
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         half_q <= 1'h0;
      end else begin
         half_q <= half_d;
      end
   end

   // Large or small sector flag
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         large_q <= 1'h0;
      end else begin
         large_q <= large_d;
      end
   end

   // Sector number within the bank
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         sect_q <= '0;
      end else begin
         sect_q <= sect_d;
      end
   end

   // Byte offset within the sector
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         off_q <= '0;
      end else begin
         off_q <= off_d;
      end
   end

   // Hit pulse, one cycle per request
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         valid_q <= 1'h0;
      end else begin
         valid_q <= valid_d;
      end
   end

   // Decode error pulse, one cycle per request
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         err_q <= 1'h0;
      end else begin
         err_q <= err_d;
      end
   end

   // Outputs come straight from the flip-flops
   assign O_SEL.arr          = arr_q;
   assign O_SEL.half         = half_q;
   assign O_SEL.large_sector = large_q;
   assign O_SEL.sector       = sect_q;
   assign O_SEL.offset       = off_q;
   assign O_VALID            = valid_q;
   assign O_ERR              = err_q;

endmodule
`default_nettype wire

/* File: fbam_pkg.sv */
package fbam_pkg;

   // Address and sector geometry
   localparam int unsigned ADDR_W      = 32;
   localparam int unsigned SECT_W      = 8;
   localparam int unsigned OFF_W       = 21;

   // Code-flash region bases and sizes
   localparam logic [31:0] CF_BASE0    = 32'h1000_0000;
   localparam logic [31:0] CF_BASE1    = 32'h1200_0000;
   localparam logic [31:0] CF_LARGE_SIZE = 32'h0000_8000;
   localparam logic [31:0] CF_SMALL_SIZE = 32'h0000_2000;
   localparam logic [7:0]  CF_LARGE_NUM  = 8'h1E;
   localparam logic [7:0]  CF_SMALL_NUM  = 8'h10;

   // Work-flash region bases and sizes
   localparam logic [31:0] WF_BASE0    = 32'h1400_0000;
   localparam logic [31:0] WF_BASE1    = 32'h1500_0000;
   localparam logic [31:0] WF_LARGE_SIZE = 32'h0000_0800;
   localparam logic [31:0] WF_SMALL_SIZE = 32'h0000_0080;
   localparam logic [7:0]  WF_LARGE_NUM  = 8'h24;
   localparam logic [7:0]  WF_SMALL_NUM  = 8'hC0;

   // Array selector
   typedef enum logic [1:0] {
      FBAM_ARR_NONE,
      FBAM_ARR_CODE,
      FBAM_ARR_WORK
   } fbam_arr_type;

   // Bank configuration for one array
   typedef struct packed {
      logic dual_bank;
      logic map_b;
   } fbam_cfg_type;

   // Decoded access towards the flash macro
   typedef struct packed {
      fbam_arr_type      arr;
      logic              half;
      logic              large_sector;
      logic [SECT_W-1:0] sector;
      logic [OFF_W-1:0]  offset;
   } fbam_sel_type;

endpackage

/* File: fbam_decode.sv */
`timescale 1ns/1ns
`default_nettype none
// Decodes one array: finds large or small sector and physical half
module fbam_decode
   import fbam_pkg::*;
#(
   parameter logic [31:0] BASE0      = 32'h0,
   parameter logic [31:0] BASE1      = 32'h0,
   parameter logic [31:0] LARGE_SIZE = 32'h1,
   parameter logic [31:0] SMALL_SIZE = 32'h1,
   parameter logic [7:0]  LARGE_NUM  = 8'h2,
   parameter logic [7:0]  SMALL_NUM  = 8'h2
) (
   input  wire logic [31:0]       i_addr,
   input  wire fbam_cfg_type      i_cfg,
   output logic                   o_hit,
   output logic                   o_half,
   output logic                   o_large_sector,
   output logic [SECT_W-1:0]      o_sector,
   output logic [OFF_W-1:0]       o_offset
);

   // Per-bank sector counts halve in dual-bank mode
   wire  [7:0]  large_cnt  = i_cfg.dual_bank ? (LARGE_NUM >> 1) : LARGE_NUM;
   wire  [7:0]  small_cnt  = i_cfg.dual_bank ? (SMALL_NUM >> 1) : SMALL_NUM;
   wire  [31:0] large_span = LARGE_SIZE * 32'(large_cnt);
   wire  [31:0] bank_len   = large_span + SMALL_SIZE * 32'(small_cnt);

   // Window offsets from each base
   wire  [31:0] rel0     = i_addr - BASE0;
   wire  [31:0] rel1     = i_addr - BASE1;
   wire         in0      = (i_addr >= BASE0) && (rel0 < bank_len);
   wire         in1      = i_cfg.dual_bank && (i_addr >= BASE1) && (rel1 < bank_len);
   wire  [31:0] rel      = in1 ? rel1 : rel0;
   wire         is_large  = rel < large_span;
   wire  [31:0] small_rel = rel - large_span;

   // Mapping B swaps which physical half answers at which base
   assign o_hit          = in0 || in1;
   assign o_half         = i_cfg.dual_bank & (in1 ^ i_cfg.map_b);
   assign o_large_sector = is_large;
   assign o_sector       = is_large ? SECT_W'(rel / LARGE_SIZE) : SECT_W'(small_rel / SMALL_SIZE);
   assign o_offset       = is_large ? OFF_W'(rel % LARGE_SIZE) : OFF_W'(small_rel % SMALL_SIZE);

endmodule
`default_nettype wire

/* File: fbam_properties.sv */
`timescale 1ns/1ns
`default_nettype none
// Checks answer timing and sample mappings at the mapper ports
module fbam_properties
   import fbam_pkg::*;
(
   input wire logic         I_CLK,
   input wire logic         I_RSTN,
   input wire logic         I_REQ,
   input wire logic [31:0]  I_ADDR,
   input wire fbam_cfg_type I_CODE_CFG,
   input wire fbam_cfg_type I_WORK_CFG,
   input wire fbam_sel_type O_SEL,
   input wire logic         O_VALID,
   input wire logic         O_ERR
);
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RSTN);
   // Request at one setting and address gives a hit with {half, large}
   property hit(cfg, m, a, hl);
      I_REQ && cfg == m && I_ADDR == a |=> O_VALID && {O_SEL.half, O_SEL.large_sector} == hl;
   endproperty
   // Answer timing and one sample per mapping
   resp_once_a: assert property (I_REQ |=> O_VALID ^ O_ERR)
      else $error("no single answer");
   err_nosel_a: assert property (O_ERR |-> O_SEL == '0)
      else $error("select on error");
   code_small_a: assert property (hit(I_CODE_CFG, 2'h0, 32'h100F_0000, 2'h0))
      else $error("code small base");
   work_small_a: assert property (hit(I_WORK_CFG, 2'h0, 32'h1401_2000, 2'h0))
      else $error("work small base");
   code_mapa_a: assert property (hit(I_CODE_CFG, 2'h2, 32'h1200_0000, 2'h3))
      else $error("code map A");
   code_mapb_a: assert property (hit(I_CODE_CFG, 2'h3, 32'h1200_0000, 2'h1))
      else $error("code map B");
   work_mapa_a: assert property (hit(I_WORK_CFG, 2'h2, 32'h1500_9000, 2'h2))
      else $error("work map A");
   work_mapb_a: assert property (hit(I_WORK_CFG, 2'h3, 32'h1400_8800, 2'h3))
      else $error("work map B");
   cover property (O_VALID && O_SEL.half);
   cover property (O_VALID && O_SEL.arr == FBAM_ARR_WORK);
   cover property (O_ERR);
endmodule
`default_nettype wire

/* File: fbam_master.sv */
`timescale 1ns/1ns
`default_nettype none
module fbam_master (
   input  wire logic        i_clk,
   input  wire logic        i_go,
   input  wire logic [31:0] i_addr,
   output logic             o_req,
   output logic [31:0]      o_addr
);
   // One request per go cycle; idle address lines alternate between the last address and its inverse
   always_ff @(posedge i_clk) begin
      o_req  <= i_go;
      o_addr <= i_go ? i_addr : ~o_addr;
   end
endmodule
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
   import fbam_pkg::*;
   localparam fbam_arr_type C = FBAM_ARR_CODE;
   localparam fbam_arr_type W = FBAM_ARR_WORK;
   logic         clk = 1'h0, rstn = 1'h0, go = 1'h0, req, vld, err;
   logic [31:0]  addr = 32'h0, a_bus;
   fbam_cfg_type cc = 2'h0, wc = 2'h0;
   fbam_sel_type sel;
   int           n_errors = 0, checks = 0;
   fbam_master fbam_master_inst (.i_clk(clk), .i_go(go), .i_addr(addr), .o_req(req),
      .o_addr(a_bus));
   fbam_top fbam_top_inst (.I_CLK(clk), .I_RSTN(rstn), .I_REQ(req), .I_ADDR(a_bus),
      .I_CODE_CFG(cc), .I_WORK_CFG(wc), .O_SEL(sel), .O_VALID(vld), .O_ERR(err));
   initial forever #25 clk = ~clk;
   function automatic fbam_sel_type mk(fbam_arr_type a, logic [1:0] hl, logic [7:0] s,
      logic [20:0] o);
      mk = {a, hl, s, o};
   endfunction
   task automatic cmp(logic [34:0] got, exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // One request via the master; answer checked after the edge that takes it
   task automatic acc(fbam_cfg_type c, w, logic [31:0] a, fbam_sel_type e);
      @(posedge clk);
      go <= 1'h1;
      addr <= a;
      cc <= c;
      wc <= w;
      @(posedge clk);
      go <= 1'h0;
      @(posedge clk);
      #1 cmp({vld, err, sel}, {e.arr != FBAM_ARR_NONE, e.arr == FBAM_ARR_NONE, e});
   endtask
   task automatic t_single;
      acc(2'h0, 2'h0, 32'h100E_8004, mk(C, 2'h1, 8'h1D, 21'h4));
      acc(2'h0, 2'h0, 32'h100F_0000, mk(C, 2'h0, 8'h0, 21'h0));
      acc(2'h0, 2'h0, 32'h1401_7F80, mk(W, 2'h0, 8'hBF, 21'h0));
      acc(2'h0, 2'h0, 32'h1200_0000, '0);
   endtask
   task automatic t_dual;
      acc(2'h2, 2'h0, 32'h1200_0000, mk(C, 2'h3, 8'h0, 21'h0));
      acc(2'h2, 2'h0, 32'h1007_7FFF, mk(C, 2'h1, 8'h0E, 21'h7FFF));
      acc(2'h2, 2'h0, 32'h1401_2000, mk(W, 2'h0, 8'h0, 21'h0));
      acc(2'h3, 2'h2, 32'h1200_0000, mk(C, 2'h1, 8'h0, 21'h0));
      acc(2'h3, 2'h2, 32'h1500_9000, mk(W, 2'h2, 8'h0, 21'h0));
      acc(2'h2, 2'h3, 32'h1400_8800, mk(W, 2'h3, 8'h11, 21'h0));
      acc(2'h2, 2'h3, 32'h1401_2000, '0);
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Reset, then scenarios
   initial begin
      repeat (2) @(posedge clk);
      rstn <= 1'h1;
      t_single();
      t_dual();
      report_and_stop();
   end
   // Watchdog
   initial begin
      repeat (500) @(posedge clk);
      n_errors++;
      report_and_stop();
   end
endmodule
bind fbam_top fbam_properties fbam_properties_inst (.I_CLK(I_CLK), .I_RSTN(I_RSTN),
   .I_REQ(I_REQ), .I_ADDR(I_ADDR), .I_CODE_CFG(I_CODE_CFG), .I_WORK_CFG(I_WORK_CFG),
   .O_SEL(O_SEL), .O_VALID(O_VALID), .O_ERR(O_ERR));
`default_nettype wire
